// ===== i2st_top.sv
// Two-wire slave transmitter with status codes and a Wishbone slave
// Functional notes
// - Own address read acked: code 0xA8, send
// - Arbitration lost then read-addressed: code 0xB0
// - Byte acked by master: code 0xB8
// - Byte not acked: code 0xC0, unaddressed
// - Last byte acked anyway: code 0xC8
// - Start request in 0xC0/0xC8 queues START
// - Flag clear shows code 0xF8
// - Misplaced START or STOP gives 0x00
// - Bus error sets the job-done flag
// - Stop plus flag clear recovers, clears stop
// - Recovery releases lines, sends no STOP
// - Repeated START keeps the bus owned
// - Flag set stretches the clock low, except after a bus error
// - After last byte, ignore further clocking
// - Status: code high, bit2 zero, prescaler
//
// The Wishbone slave port and the register addresses were decided locally.
`timescale 1ns/100ps
module i2st_top
    import i2st_pkg::*;
(
    input  wire logic        clk_sys,
    input  wire logic        arst_n,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [31:0] wb_dat_i,
    input  wire logic [3:0]  wb_sel_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    input  wire logic        scl_i,
    output logic             scl_o,
    output logic             scl_oe,
    input  wire logic        sda_i,
    output logic             sda_o,
    output logic             sda_oe,
    input  wire logic        arb_lost_i,
    output logic             bus_claimed_o
);

    // ****************************************************************
    // Helpers
    // ****************************************************************
    function automatic logic hit(input logic [7:0] a,
                                 input logic [7:0] off);
        return a == off;
    endfunction

    // ****************************************************************
    // Declarations
    // ****************************************************************
    logic [1:0]  pin_sync;
    logic        scl_s;
    logic        sda_s;
    logic        scl_d_reg;
    logic        sda_d_reg;
    logic        scl_rise;
    logic        scl_fall;
    logic        start_det;
    logic        stop_det;
    i2st_state_t state_reg;
    i2st_state_t state_next;
    logic        ev_set;
    logic [7:0]  ev_code;
    logic        frame_err;
    logic        wb_req;
    logic        wr_en;
    logic        ctl_wr;
    logic        dat_wr;
    logic        wr_done_clr;
    logic        recover;
    logic        done_reg;
    logic        acken_reg;
    logic        sta_reg;
    logic        sto_reg;
    logic        wcol_reg;
    logic        en_reg;
    logic [7:0]  own_reg;
    logic [1:0]  pre_reg;
    logic [7:0]  data_reg;
    logic [7:0]  code_reg;
    logic [4:0]  stat_code;
    logic [7:0]  shift_reg;
    logic [3:0]  bcnt_reg;
    logic        last_reg;
    logic        mack_reg;
    logic        arb_reg;
    logic        busy_reg;
    logic        startq_reg;
    logic [11:0] hold_cnt_reg;
    logic        hold_done;
    logic        own_gen;
    logic        addr_ok;

    // ****************************************************************
    // Pin synchronisation and bus condition detection
    // ****************************************************************
    i2st_sync u_sync (
        .clk_sys  (clk_sys),
        .arst_n   (arst_n),
        .pin_in   ({sda_i, scl_i}),
        .pin_sync (pin_sync)
    );

    assign scl_s = pin_sync[0];
    assign sda_s = pin_sync[1];

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            scl_d_reg <= 1'h1;
            sda_d_reg <= 1'h1;
        end else begin
            scl_d_reg <= scl_s;
            sda_d_reg <= sda_s;
        end
    end

    // Our own START must not be seen as someone else's
    assign own_gen   = (state_reg == S_GEN) || (state_reg == S_OWN);
    assign scl_rise  = scl_s & ~scl_d_reg;
    assign scl_fall  = ~scl_s & scl_d_reg;
    assign start_det = ~own_gen & scl_s & scl_d_reg & sda_d_reg & ~sda_s;
    assign stop_det  = ~own_gen & scl_s & scl_d_reg & ~sda_d_reg & sda_s;

    // ****************************************************************
    // Wishbone decode
    // ****************************************************************
    assign wb_req      = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    assign wr_en       = wb_req & wb_we_i & wb_sel_i[0];
    assign ctl_wr      = wr_en & hit(wb_adr_i, ADR_CTRL);
    assign dat_wr      = wr_en & hit(wb_adr_i, ADR_DATA);
    assign wr_done_clr = ctl_wr & wb_dat_i[CTL_DONE];
    assign recover     = wr_done_clr & wb_dat_i[CTL_STO];
    assign addr_ok     = (shift_reg[7:1] == own_reg[7:1]) & shift_reg[0]
                         & acken_reg;

    // ****************************************************************
    // Transfer state machine
    // ****************************************************************
    always_comb begin
        state_next = state_reg;
        ev_set     = 1'h0;
        ev_code    = code_reg;
        frame_err  = 1'h0;
        case (state_reg)
            S_IDLE: begin
                if (startq_reg && !busy_reg) begin
                    state_next = S_GEN;
                end else if (start_det) begin
                    state_next = S_ADDR;
                end
            end
            S_ADDR: begin
                if (start_det || stop_det) begin
                    if (bcnt_reg != 4'h0) begin
                        frame_err = 1'h1;
                    end else if (stop_det) begin
                        state_next = S_IDLE;
                    end
                end else if (scl_fall && bcnt_reg == BITS_PER_BYTE) begin
                    state_next = addr_ok ? S_AACK : S_IDLE;
                end
            end
            S_AACK: begin
                if (start_det || stop_det) begin
                    frame_err = 1'h1;
                end else if (scl_fall) begin
                    ev_set     = 1'h1;
                    ev_code    = arb_reg ? ST_ARB_RD : ST_ADDR_RD;
                    state_next = S_WAIT;
                end
            end
            S_WAIT: begin
                if (!done_reg) begin
                    state_next = S_TX;
                end
            end
            S_TX: begin
                if (start_det || stop_det) begin
                    frame_err = 1'h1;
                end else if (scl_fall && bcnt_reg == TX_LAST_BIT) begin
                    state_next = S_MACK;
                end
            end
            S_MACK: begin
                if (start_det || stop_det) begin
                    frame_err = 1'h1;
                end else if (scl_fall) begin
                    ev_set = 1'h1;
                    if (!mack_reg) begin
                        ev_code    = ST_DATA_NACK;
                        state_next = S_END;
                    end else if (last_reg) begin
                        ev_code    = ST_LAST_ACK;
                        state_next = S_END;
                    end else begin
                        ev_code    = ST_DATA_ACK;
                        state_next = S_WAIT;
                    end
                end
            end
            S_END: begin
                if (!done_reg) begin
                    state_next = S_IDLE;
                end
            end
            S_ERR: begin
                state_next = S_ERR;
            end
            S_GEN: begin
                if (hold_done) begin
                    state_next = S_OWN;
                end
            end
            S_OWN: begin
                if (!sta_reg) begin
                    state_next = S_IDLE;
                end
            end
            default: begin
                state_next = S_IDLE;
            end
        endcase
        if (frame_err) begin
            ev_set     = 1'h1;
            ev_code    = ST_BUS_ERR;
            state_next = S_ERR;
        end
        if (recover || !en_reg) begin
            state_next = S_IDLE;
        end
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            state_reg <= S_IDLE;
        end else begin
            state_reg <= state_next;
        end
    end

    // ****************************************************************
    // Shifter, bit counter, master acknowledge
    // ****************************************************************
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            shift_reg <= 8'h00;
            bcnt_reg  <= 4'h0;
            last_reg  <= 1'h0;
            mack_reg  <= 1'h0;
        end else if (start_det) begin
            bcnt_reg <= 4'h0;
        end else if (state_reg == S_ADDR) begin
            if (scl_rise && bcnt_reg != BITS_PER_BYTE) begin
                shift_reg <= {shift_reg[6:0], sda_s};
                bcnt_reg  <= bcnt_reg + 4'h1;
            end
        end else if (state_reg == S_WAIT && state_next == S_TX) begin
            shift_reg <= data_reg;
            bcnt_reg  <= 4'h0;
            last_reg  <= ~acken_reg;
        end else if (state_reg == S_TX && scl_fall) begin
            shift_reg <= {shift_reg[6:0], 1'h1};
            bcnt_reg  <= bcnt_reg + 4'h1;
        end else if (state_reg == S_MACK && scl_rise) begin
            mack_reg <= ~sda_s;
        end
    end

    // ****************************************************************
    // Bus ownership, arbitration latch, START generation
    // ****************************************************************
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            busy_reg <= 1'h0;
        end else if (start_det) begin
            busy_reg <= 1'h1;
        end else if (stop_det) begin
            busy_reg <= 1'h0;
        end
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            arb_reg <= 1'h0;
        end else if (arb_lost_i) begin
            arb_reg <= 1'h1;
        end else if (state_reg == S_WAIT || state_reg == S_IDLE) begin
            arb_reg <= 1'h0;
        end
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            startq_reg <= 1'h0;
        end else if (state_reg == S_END && wr_done_clr
                     && wb_dat_i[CTL_STA]) begin
            startq_reg <= 1'h1;
        end else if (state_reg == S_GEN || !en_reg) begin
            startq_reg <= 1'h0;
        end
    end

    assign hold_done = hold_cnt_reg == 12'(START_HOLD_CYC - 1);

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            hold_cnt_reg <= 12'h000;
        end else if (state_reg == S_GEN && !hold_done) begin
            hold_cnt_reg <= hold_cnt_reg + 12'h001;
        end else if (state_reg != S_GEN) begin
            hold_cnt_reg <= 12'h000;
        end
    end

    // ****************************************************************
    // Pin drivers, open drain: only ever pull low
    // ****************************************************************
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            scl_o  <= 1'h0;
            sda_o  <= 1'h0;
            scl_oe <= 1'h0;
            sda_oe <= 1'h0;
        end else begin
            scl_o  <= 1'h0;
            sda_o  <= 1'h0;
            // Error state leaves both lines released
            scl_oe <= (done_reg && (state_reg == S_WAIT
                       || state_reg == S_END))
                      || state_reg == S_OWN;
            // Released bits after the last byte read as ones
            sda_oe <= (state_reg == S_AACK)
                      || (state_reg == S_TX && !shift_reg[7])
                      || own_gen;
        end
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            bus_claimed_o <= 1'h0;
        end else begin
            bus_claimed_o <= state_reg == S_OWN;
        end
    end

    // ****************************************************************
    // Software registers
    // ****************************************************************
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            done_reg <= 1'h0;
            code_reg <= ST_NO_INFO;
        end else if (ev_set) begin
            done_reg <= 1'h1;
            code_reg <= ev_code;
        end else if (wr_done_clr) begin
            done_reg <= 1'h0;
        end
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            acken_reg <= 1'h0;
            sta_reg   <= 1'h0;
            sto_reg   <= 1'h0;
            en_reg    <= 1'h0;
        end else if (ctl_wr) begin
            acken_reg <= wb_dat_i[CTL_ACKEN];
            sta_reg   <= wb_dat_i[CTL_STA];
            // Recovery consumes the stop request at once
            sto_reg   <= wb_dat_i[CTL_STO] & ~recover;
            en_reg    <= wb_dat_i[CTL_EN];
        end
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            wcol_reg <= 1'h0;
            data_reg <= DATA_RST;
        end else if (dat_wr) begin
            wcol_reg <= ~done_reg;
            if (done_reg) begin
                data_reg <= wb_dat_i[7:0];
            end
        end
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            own_reg <= OWN_RST;
            pre_reg <= PRE_RST;
        end else if (wr_en && hit(wb_adr_i, ADR_OWN)) begin
            own_reg <= wb_dat_i[7:0];
        end else if (wr_en && hit(wb_adr_i, ADR_STAT)) begin
            pre_reg <= wb_dat_i[PRE_HI:0];
        end
    end

    // ****************************************************************
    // Read path and acknowledge
    // ****************************************************************
    assign stat_code = done_reg ? code_reg[STAT_HI:STAT_LO]
                                : ST_NO_INFO[STAT_HI:STAT_LO];

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            wb_ack_o <= 1'h0;
            wb_dat_o <= 32'h0000_0000;
        end else begin
            wb_ack_o <= wb_req;
            wb_dat_o <= 32'h0000_0000;
            if (wb_req && !wb_we_i) begin
                if (hit(wb_adr_i, ADR_CTRL)) begin
                    wb_dat_o[7:0] <= {done_reg, acken_reg, sta_reg,
                                      sto_reg, wcol_reg, en_reg, 2'h0};
                end else if (hit(wb_adr_i, ADR_STAT)) begin
                    wb_dat_o[7:0] <= {stat_code, 1'h0, pre_reg};
                end else if (hit(wb_adr_i, ADR_DATA)) begin
                    wb_dat_o[7:0] <= data_reg;
                end else if (hit(wb_adr_i, ADR_OWN)) begin
                    wb_dat_o[7:0] <= own_reg;
                end
            end
        end
    end

    // ****************************************************************
    // Assertions
    // ****************************************************************
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!arst_n);

    sequence s_mack_end;
        state_reg == S_MACK && scl_fall && !start_det && !stop_det
        && !recover && en_reg;
    endsequence

    sequence s_stat_rd;
        wb_req && !wb_we_i && hit(wb_adr_i, ADR_STAT);
    endsequence

    addr_read_code_a: assert property (
        state_reg == S_AACK && scl_fall && !arb_reg && !stop_det
        && !recover && en_reg |=> done_reg && code_reg == ST_ADDR_RD
        ##1 scl_oe) else $error("own read address code wrong");
    arb_read_code_a: assert property (
        state_reg == S_AACK && scl_fall && arb_reg && !stop_det
        && !recover && en_reg |=> code_reg == ST_ARB_RD)
        else $error("arbitration read code wrong");
    data_ack_code_a: assert property (
        s_mack_end and (mack_reg && !last_reg)
        |=> code_reg == ST_DATA_ACK && state_reg == S_WAIT)
        else $error("acked byte code wrong");
    data_nack_code_a: assert property (
        s_mack_end and !mack_reg
        |=> code_reg == ST_DATA_NACK && state_reg == S_END)
        else $error("nacked byte code wrong");
    last_ack_code_a: assert property (
        s_mack_end and (mack_reg && last_reg)
        |=> code_reg == ST_LAST_ACK && state_reg == S_END)
        else $error("last byte acked code wrong");
    start_queue_a: assert property (
        state_reg == S_END && wr_done_clr && wb_dat_i[CTL_STA] && en_reg
        |=> startq_reg) else $error("start request not queued");
    idle_status_a: assert property (
        s_stat_rd and !done_reg |=> wb_ack_o
        && wb_dat_o[7:3] == ST_NO_INFO[7:3])
        else $error("idle status not shown");
    bus_err_code_a: assert property (
        frame_err && !recover && en_reg
        |=> done_reg && code_reg == ST_BUS_ERR && state_reg == S_ERR)
        else $error("bus error not reported");
    err_recover_a: assert property (
        recover |=> state_reg == S_IDLE && !sto_reg && !done_reg)
        else $error("recovery failed");
    err_release_a: assert property (
        (state_reg == S_ERR) [*2] |-> !scl_oe && !sda_oe)
        else $error("lines held in error state");
    rep_start_busy_a: assert property (
        start_det && busy_reg |=> busy_reg)
        else $error("repeated start dropped ownership");
    clock_stretch_a: assert property (
        (state_reg == S_WAIT && done_reg) [*2] |-> scl_oe)
        else $error("clock not stretched");
    last_ignore_a: assert property (
        (state_reg == S_END || state_reg == S_IDLE) [*2] |-> !sda_oe)
        else $error("data line driven after last byte");
    status_layout_a: assert property (
        s_stat_rd |=> !wb_dat_o[2] && wb_dat_o[1:0] == $past(pre_reg))
        else $error("status layout wrong");

endmodule // i2st_top

// ===== i2st_pkg.sv
// Constants and types shared by the two-wire slave transmitter block
package i2st_pkg;

    // ****************************************************************
    // Register map (byte addresses, one aligned word each)
    // ****************************************************************
    localparam logic [7:0] ADR_CTRL = 8'h00;
    localparam logic [7:0] ADR_STAT = 8'h04;
    localparam logic [7:0] ADR_DATA = 8'h08;
    localparam logic [7:0] ADR_OWN  = 8'h0c;

    // ****************************************************************
    // Control register fields
    // ****************************************************************
    localparam int CTL_DONE  = 7;
    localparam int CTL_ACKEN = 6;
    localparam int CTL_STA   = 5;
    localparam int CTL_STO   = 4;
    localparam int CTL_WCOL  = 3;
    localparam int CTL_EN    = 2;

    // ****************************************************************
    // Status and address register fields
    // ****************************************************************
    localparam int STAT_HI  = 7;
    localparam int STAT_LO  = 3;
    localparam int STAT_RSV = 2;
    localparam int PRE_HI   = 1;
    localparam int OWN_GCE  = 0;

    // ****************************************************************
    // Reset values
    // ****************************************************************
    localparam logic [7:0] OWN_RST  = 8'h00;
    localparam logic [7:0] DATA_RST = 8'hff;
    localparam logic [1:0] PRE_RST  = 2'h0;

    // ****************************************************************
    // Status codes, prescaler bits masked to zero
    // ****************************************************************
    localparam logic [7:0] ST_ADDR_RD   = 8'ha8;
    localparam logic [7:0] ST_ARB_RD    = 8'hb0;
    localparam logic [7:0] ST_DATA_ACK  = 8'hb8;
    localparam logic [7:0] ST_DATA_NACK = 8'hc0;
    localparam logic [7:0] ST_LAST_ACK  = 8'hc8;
    localparam logic [7:0] ST_NO_INFO   = 8'hf8;
    localparam logic [7:0] ST_BUS_ERR   = 8'h00;

    // ****************************************************************
    // Framing and timing
    // ****************************************************************
    localparam logic [3:0] BITS_PER_BYTE = 4'h8;
    localparam logic [3:0] TX_LAST_BIT   = 4'h7;
    localparam int SYS_CLK_MHZ    = 250;
    localparam int START_HOLD_NS  = 4000;
    localparam int START_HOLD_CYC =
        (START_HOLD_NS * SYS_CLK_MHZ + 999) / 1000;

    typedef enum logic [3:0] {
        S_IDLE, S_ADDR, S_AACK, S_WAIT, S_TX, S_MACK,
        S_END, S_ERR, S_GEN, S_OWN
    } i2st_state_t;

endpackage

// ===== i2st_sync.sv
// Two-stage synchroniser for the bus clock and data pins
`timescale 1ns/100ps
module i2st_sync (
    input  wire logic       clk_sys,
    input  wire logic       arst_n,
    input  wire logic [1:0] pin_in,
    output logic      [1:0] pin_sync
);
    logic [1:0] meta_reg;

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            meta_reg <= 2'h3;
            pin_sync <= 2'h3;
        end else begin
            meta_reg <= pin_in;
            pin_sync <= meta_reg;
        end
    end
endmodule // i2st_sync

// ===== i2st_master.sv
// Bus master receiver model driving the open-drain clock and data lines
`timescale 1ns/100ps
module i2st_master (
    input  wire logic clk_sys,
    input  wire logic scl,
    input  wire logic sda,
    output logic      scl_oe,
    output logic      sda_oe
);
    int stalls = 0;
    initial {scl_oe, sda_oe} = 2'b00;
    // Slave may stretch the low phase; the wait is bounded
    task automatic up();
        repeat (10) @(posedge clk_sys);
        scl_oe <= 1'b0;
        for (int n = 0; n < 4000 && (n < 2 || scl !== 1'b1); n++)
            @(posedge clk_sys);
        if (scl !== 1'b1) stalls++;
        // High and low phases of 80 ns each: a 160 ns bus clock
        repeat (18) @(posedge clk_sys);
    endtask
    task automatic bt(input logic b, output logic r);
        sda_oe <= !b;
        up();
        r = sda;
        scl_oe <= 1'b1;
        repeat (10) @(posedge clk_sys);
    endtask
    // Start (s=1, also repeated) or stop (s=0)
    task automatic cond(input logic s);
        sda_oe <= !s;
        up();
        sda_oe <= s;
        repeat (10) @(posedge clk_sys);
        scl_oe <= s;
        repeat (10) @(posedge clk_sys);
    endtask
    task automatic xfer(input logic [7:0] v, input logic a,
                        output logic [7:0] r, output logic g);
        for (int i = 7; i >= 0; i--) bt(v[i], r[i]);
        bt(a, g);
    endtask
endmodule // i2st_master

// ===== test_i2st_top.sv
// Self-checking bench for the two-wire slave transmitter
`timescale 1ns/100ps
`define CHK(a, e) begin checks_done++; if ((a) !== (e)) begin \
    mismatches++; \
    $display("CHECK FAILED %0t got %h exp %h", $time, a, e); end end
module test_i2st_top import i2st_pkg::*;;
    logic        clk_sys = 1'b0, arst_n = 1'b0, wb_cyc_i = 1'b0;
    logic        wb_we_i = 1'b0, arb_lost_i = 1'b0, ak, m_scl, m_sda;
    logic        wb_stb_i = 1'b0, scl_o, sda_o;
    logic [3:0]  wb_sel_i = 4'h0, sel_use = 4'h1;
    logic [7:0]  wb_adr_i = 8'h00, r8;
    logic [31:0] wb_dat_i = 32'h0, wb_dat_o;
    logic        wb_ack_o, scl_oe, sda_oe, bus_claimed_o;
    wire         scl_i = !(scl_oe | m_scl), sda_i = !(sda_oe | m_sda);
    int          mismatches = 0, checks_done = 0;
    i2st_top dut_u (.clk_sys, .arst_n, .wb_cyc_i, .wb_stb_i,
        .wb_we_i, .wb_adr_i, .wb_dat_i, .wb_sel_i, .wb_dat_o, .wb_ack_o,
        .scl_i, .scl_o, .scl_oe, .sda_i, .sda_o, .sda_oe, .arb_lost_i,
        .bus_claimed_o);
    i2st_master m_u (.clk_sys, .scl(scl_i), .sda(sda_i), .scl_oe(m_scl),
        .sda_oe(m_sda));
    initial forever #2 clk_sys = ~clk_sys;
    // Reads compare against d; writes just store it
    task automatic wb(input logic w, input logic [7:0] a, d);
        @(posedge clk_sys);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_sel_i <= sel_use;
        wb_we_i  <= w;
        wb_adr_i <= a;
        wb_dat_i <= {24'h0, d};
        for (int n = 0; n < 50 && (n < 1 || wb_ack_o !== 1'b1); n++)
            @(posedge clk_sys);
        if (wb_ack_o !== 1'b1) begin
            mismatches++;
            results();
        end
        if (!w) `CHK(wb_dat_o, {24'h0, d})
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
    endtask
    task automatic results();
        $display("checks_done %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    initial begin
        repeat (6) @(posedge clk_sys);
        arst_n <= 1'b1;
        wb(1'b0, 8'h10, 8'h00);
        wb(1'b1, ADR_OWN, 8'h54);
        wb(1'b1, ADR_CTRL, 8'h44);
        m_u.cond(1'b1);
        m_u.xfer(8'h54, 1'b1, r8, ak);
        m_u.cond(1'b1);
        m_u.xfer(8'h55, 1'b1, r8, ak);
        `CHK({ak, scl_oe, scl_o}, 3'b010)
        wb(1'b0, ADR_STAT, ST_ADDR_RD);
        wb(1'b1, ADR_DATA, 8'h3c);
        wb(1'b1, ADR_CTRL, 8'hc4);
        m_u.xfer(8'hff, 1'b0, r8, ak);
        `CHK(r8, 8'h3c)
        wb(1'b0, ADR_STAT, ST_DATA_ACK);
        wb(1'b1, ADR_DATA, 8'ha5);
        wb(1'b1, ADR_CTRL, 8'h84);
        m_u.xfer(8'hff, 1'b0, r8, ak);
        `CHK(r8, 8'ha5)
        wb(1'b0, ADR_STAT, ST_LAST_ACK);
        wb(1'b1, ADR_CTRL, 8'hc4);
        m_u.xfer(8'hff, 1'b0, r8, ak);
        `CHK(r8, 8'hff)
        $display("test 1 done");
        m_u.cond(1'b1);
        m_u.xfer(8'h55, 1'b1, r8, ak);
        wb(1'b1, ADR_DATA, 8'hff);
        wb(1'b1, ADR_CTRL, 8'hc4);
        m_u.xfer(8'hff, 1'b1, r8, ak);
        wb(1'b0, ADR_STAT, ST_DATA_NACK);
        wb(1'b1, ADR_CTRL, 8'he4);
        `CHK(bus_claimed_o, 1'b0)
        m_u.cond(1'b0);
        for (int n = 0; n < 1500 && bus_claimed_o !== 1'b1; n++)
            @(posedge clk_sys);
        `CHK({bus_claimed_o, sda_i, sda_o}, 3'b100)
        wb(1'b1, ADR_CTRL, 8'h44);
        $display("test 2 done");
        m_u.cond(1'b1);
        arb_lost_i <= 1'b1;
        @(posedge clk_sys);
        arb_lost_i <= 1'b0;
        m_u.xfer(8'h55, 1'b1, r8, ak);
        wb(1'b0, ADR_STAT, ST_ARB_RD);
        wb(1'b1, ADR_CTRL, 8'hc4);
        m_u.bt(1'b1, ak);
        // Start inside a data byte; loaded 0xff keeps the slave off SDA
        m_u.cond(1'b1);
        wb(1'b0, ADR_STAT, ST_BUS_ERR);
        wb(1'b0, ADR_CTRL, 8'hc4);
        `CHK({scl_oe, sda_oe}, 2'b00)
        wb(1'b1, ADR_CTRL, 8'hd4);
        wb(1'b0, ADR_CTRL, 8'h44);
        $display("test 3 done");
        wb(1'b1, ADR_STAT, 8'h03);
        wb(1'b0, ADR_STAT, 8'hfb);
        // Write with byte lane 0 off must be ignored
        sel_use = 4'h0;
        wb(1'b1, ADR_OWN, 8'h00);
        sel_use = 4'h1;
        wb(1'b0, ADR_OWN, 8'h54);
        // Data write with flag low: dropped, collision bit set
        wb(1'b1, ADR_DATA, 8'h12);
        wb(1'b0, ADR_CTRL, 8'h4c);
        wb(1'b0, ADR_DATA, 8'hff);
        `CHK(m_u.stalls, 0)
        $display("test 4 done");
        results();
    end
endmodule // test_i2st_top
